// [src/slc_pkg.sv]
package slc_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0]  CTRL_OFS       = 4'h0;
  localparam logic [3:0]  STAT_OFS       = 4'h4;
  localparam int          CTRL_PTL_BIT   = 0;
  localparam int          CTRL_OPEN_BIT  = 1;
  localparam logic [1:0]  CTRL_RST       = 2'h0;
  localparam int          STAT_SAFE_BIT  = 0;
  localparam int          STAT_DIAG_BIT  = 1;
  localparam int          STAT_LOCK_BIT  = 2;
  localparam int          STAT_WARN_BIT  = 3;
  localparam int          STAT_ERR_BIT   = 4;
  localparam int          STAT_CODE_LSB  = 8;

  // ==========================================================
  // timing
  localparam longint      CLK_HZ         = 200_000_000;
  localparam longint      WARN_MIN       = 30;
  localparam longint      ESC_CYC        = WARN_MIN * 60 * CLK_HZ;
  localparam longint      GREEN_HZ       = 1;
  localparam longint      GREEN_HALF_CYC = CLK_HZ / (2 * GREEN_HZ);
  localparam longint      PULSE_MS       = 250;
  localparam longint      PULSE_CYC      = CLK_HZ * PULSE_MS / 1000;
  localparam logic [3:0]  PAUSE_SLOTS    = 4'h4;

  // ==========================================================
  // red flash codes
  localparam logic [2:0]  CODE_NONE      = 3'h0;
  localparam logic [2:0]  CODE_OUT_A     = 3'h1;
  localparam logic [2:0]  CODE_OUT_B     = 3'h2;
  localparam logic [2:0]  CODE_CROSS     = 3'h3;
  localparam logic [2:0]  CODE_TEMP      = 3'h4;
  localparam logic [2:0]  CODE_ACTUATOR  = 3'h5;
  localparam logic [2:0]  CODE_HANDLE    = 3'h6;
  localparam logic [2:0]  CODE_STEADY    = 3'h7;

  typedef enum logic [2:0] {
    ERR_RUN    = 3'b001,
    ERR_LATCH  = 3'b010,
    ERR_OPENED = 3'b100
  } slc_err_e;

  typedef struct packed {
    logic internal_err;
    logic handle_bad;
    logic actuator_bad;
    logic overtemp;
    logic cross_short;
    logic out_b_fault;
    logic out_a_fault;
  } slc_fault_s;

  typedef struct packed {
    logic guard_closed;
    logic actuator_valid;
    logic lock_possible;
  } slc_guard_s;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } slc_led_s;

endpackage : slc_pkg

// [src/slc_ctrl.sv]
`timescale 1ns/1ps
// Contract
// - power-to-unlock: input high releases, low locks
// - power-to-lock: input high locks, low releases
// - unlock-disables: releasing lock drops both outputs
// - unlock-disables: relock with actuator re-enables outputs
// - open-disables: guard opening drops outputs, releasing lock does not
// - green supply, yellow condition, red flash codes
// - chain missing: green 1 Hz, red off unless an error is latched
// - internal error: outputs off, red continuous
// - error clears after guard open then close
// - warning: diagnostic low, outputs stay enabled
// - warning clears itself when cause gone
// - warning held for period: outputs off
// - output a fault: one pulse, escalates
// - output b fault: two pulses, escalates
// - cross-short or both faulty: three pulses
// - overtemperature: four pulses
// - bad actuator: immediate fault, five pulses
// - handle intermediate position: immediate fault, six pulses
module slc_ctrl #(
  parameter longint ESC_CYC        = slc_pkg::ESC_CYC,
  parameter longint GREEN_HALF_CYC = slc_pkg::GREEN_HALF_CYC,
  parameter longint PULSE_CYC      = slc_pkg::PULSE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               magnet_ctrl_in,
  input  wire logic               chain_enable_input_a,
  input  wire logic               chain_enable_input_b,
  input  wire slc_pkg::slc_guard_s guard,
  input  wire slc_pkg::slc_fault_s fault,
  output logic                    lock_engaged,
  output logic                    safety_output_a,
  output logic                    safety_output_b,
  output logic                    diag_out,
  output slc_pkg::slc_led_s       led
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]        ctrl;
    logic              ack;
    logic [31:0]       rdat;
    slc_pkg::slc_err_e est;
    logic [2:0]        err_code;
    logic [39:0]       warn_cnt;
    logic [31:0]       green_cnt;
    logic              green_ph;
    logic [31:0]       pulse_cnt;
    logic [3:0]        slot;
    logic              locked;
    logic              safe;
    logic              diag;
    logic              warn;
    slc_pkg::slc_led_s led;
  } slc_state_s;

  slc_state_s st_r;
  slc_state_s st_nxt;

  logic       ptl;
  logic       open_dis;
  logic       lock_cmd;
  logic       chain_ok;
  logic       warn_now;
  logic [2:0] wcode;
  logic       immed;
  logic       cause;
  logic       escal;
  logic [2:0] show_code;
  logic [3:0] n2;
  logic [3:0] slot_end;

  // ==========================================================
  // combinational decode
  always_comb
  begin
    ptl      = st_r.ctrl[slc_pkg::CTRL_PTL_BIT];
    open_dis = st_r.ctrl[slc_pkg::CTRL_OPEN_BIT];
    lock_cmd = ptl ? magnet_ctrl_in : ~magnet_ctrl_in;
    chain_ok = chain_enable_input_a & chain_enable_input_b;
    warn_now = fault.out_a_fault | fault.out_b_fault | fault.cross_short | fault.overtemp;
    if (fault.cross_short | (fault.out_a_fault & fault.out_b_fault))
      wcode = slc_pkg::CODE_CROSS;
    else if (fault.out_a_fault)
      wcode = slc_pkg::CODE_OUT_A;
    else if (fault.out_b_fault)
      wcode = slc_pkg::CODE_OUT_B;
    else if (fault.overtemp)
      wcode = slc_pkg::CODE_TEMP;
    else
      wcode = slc_pkg::CODE_NONE;
    immed = fault.internal_err | fault.handle_bad | fault.actuator_bad;
    escal = warn_now && (st_r.warn_cnt == 40'(ESC_CYC - 1));
    cause = immed | warn_now;
    // code on the red led: latched error first, else the live warning
    show_code = (st_r.est != slc_pkg::ERR_RUN) ? st_r.err_code
              : (st_r.warn ? wcode : slc_pkg::CODE_NONE);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // wishbone slave, ack one cycle after request, dropped next cycle
    st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    if (wb_cyc_i & wb_stb_i & ~st_r.ack)
    begin
      st_nxt.rdat = 32'h0;
      if (wb_adr_i == slc_pkg::CTRL_OFS)
      begin
        st_nxt.rdat[1:0] = st_r.ctrl;
        if (wb_we_i && wb_sel_i[0])
          st_nxt.ctrl = wb_dat_i[1:0];
      end
      else if (wb_adr_i == slc_pkg::STAT_OFS)
      begin
        st_nxt.rdat[slc_pkg::STAT_SAFE_BIT] = st_r.safe;
        st_nxt.rdat[slc_pkg::STAT_DIAG_BIT] = st_r.diag;
        st_nxt.rdat[slc_pkg::STAT_LOCK_BIT] = st_r.locked;
        st_nxt.rdat[slc_pkg::STAT_WARN_BIT] = st_r.warn;
        st_nxt.rdat[slc_pkg::STAT_ERR_BIT]  = (st_r.est != slc_pkg::ERR_RUN);
        st_nxt.rdat[slc_pkg::STAT_CODE_LSB +: 3] = show_code;
      end
    end

    // lock follows command only with a valid actuator in a lockable guard
    st_nxt.locked = lock_cmd & guard.guard_closed & guard.actuator_valid
                    & guard.lock_possible;

    // warning is live from its causes, no reset needed
    st_nxt.warn = warn_now;
    if (!warn_now)
      st_nxt.warn_cnt = 40'h0;
    else if (!escal)
      st_nxt.warn_cnt = st_r.warn_cnt + 40'h1;

    // error latch: set wins over clear
    case (st_r.est)
      slc_pkg::ERR_RUN:
      begin
        if (immed | escal)
          st_nxt.est = slc_pkg::ERR_LATCH;
      end
      slc_pkg::ERR_LATCH:
      begin
        if (!cause && !guard.guard_closed)
          st_nxt.est = slc_pkg::ERR_OPENED;
      end
      slc_pkg::ERR_OPENED:
      begin
        if (immed | escal)
          st_nxt.est = slc_pkg::ERR_LATCH;
        else if (guard.guard_closed)
          st_nxt.est = slc_pkg::ERR_RUN;
      end
      default:
        st_nxt.est = slc_pkg::ERR_LATCH;
    endcase
    if (fault.internal_err)
      st_nxt.err_code = slc_pkg::CODE_STEADY;
    else if (fault.handle_bad)
      st_nxt.err_code = slc_pkg::CODE_HANDLE;
    else if (fault.actuator_bad)
      st_nxt.err_code = slc_pkg::CODE_ACTUATOR;
    else if (escal)
      st_nxt.err_code = wcode;
    else if (st_nxt.est == slc_pkg::ERR_RUN)
      st_nxt.err_code = slc_pkg::CODE_NONE;

    // safety outputs; immediate faults act at the next clock edge, one cycle later
    st_nxt.safe = chain_ok & guard.guard_closed & guard.actuator_valid
                  & ~immed & ~escal & (st_nxt.est == slc_pkg::ERR_RUN);
    if (!open_dis)
      st_nxt.safe = st_nxt.safe & st_nxt.locked;

    // diagnostic output, warnings keep outputs enabled
    st_nxt.diag = guard.guard_closed & guard.actuator_valid & guard.lock_possible
                  & ~warn_now & ~cause & (st_nxt.est == slc_pkg::ERR_RUN);

    // 1 Hz green blink
    if (st_r.green_cnt >= 32'(GREEN_HALF_CYC - 1))
    begin
      st_nxt.green_cnt = 32'h0;
      st_nxt.green_ph  = ~st_r.green_ph;
    end
    else
      st_nxt.green_cnt = st_r.green_cnt + 32'h1;

    // red pulse train: n pulses then a pause
    n2 = {show_code, 1'b0};
    slot_end = n2 + slc_pkg::PAUSE_SLOTS;
    if (st_r.pulse_cnt >= 32'(PULSE_CYC - 1))
    begin
      st_nxt.pulse_cnt = 32'h0;
      st_nxt.slot = (st_r.slot >= slot_end - 4'h1) ? 4'h0 : st_r.slot + 4'h1;
    end
    else
      st_nxt.pulse_cnt = st_r.pulse_cnt + 32'h1;

    // indicators
    st_nxt.led.green  = chain_ok ? 1'b1 : st_r.green_ph;
    if (!guard.guard_closed || st_r.est != slc_pkg::ERR_RUN)
      st_nxt.led.yellow = 1'b0;
    else if (st_r.locked)
      st_nxt.led.yellow = 1'b1;
    else
      st_nxt.led.yellow = st_r.green_ph;
    if (!chain_ok && st_r.est == slc_pkg::ERR_RUN)
      st_nxt.led.red = 1'b0;
    else if (show_code == slc_pkg::CODE_STEADY)
      st_nxt.led.red = 1'b1;
    else if (show_code == slc_pkg::CODE_NONE)
      st_nxt.led.red = 1'b0;
    else
      st_nxt.led.red = (st_r.slot < n2) & ~st_r.slot[0];
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r           <= '0;
      st_r.ctrl      <= slc_pkg::CTRL_RST;
      st_r.est       <= slc_pkg::ERR_RUN;
      st_r.led.green <= 1'b1;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  assign wb_dat_o        = st_r.rdat;
  assign wb_ack_o        = st_r.ack;
  assign lock_engaged    = st_r.locked;
  assign safety_output_a = st_r.safe;
  assign safety_output_b = st_r.safe;
  assign diag_out        = st_r.diag;
  assign led             = st_r.led;

endmodule : slc_ctrl

// [verification/slc_checker.sv]
`timescale 1ns/1ps
module slc_checker #(
  parameter longint GREEN_HALF_CYC = 4
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                ce,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic                chain_enable_input_a,
  input wire logic                chain_enable_input_b,
  input wire slc_pkg::slc_guard_s guard,
  input wire slc_pkg::slc_fault_s fault,
  input wire logic                safety_output_a,
  input wire logic                safety_output_b,
  input wire logic                diag_out,
  input wire slc_pkg::slc_led_s   led
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // safety outputs
  pair_same_a: assert property (safety_output_a == safety_output_b)
    else $error("safety outputs differ");
  open_off_a: assert property (!guard.guard_closed |=> !safety_output_a)
    else $error("outputs on with guard open");
  chain_off_a: assert property (!(chain_enable_input_a && chain_enable_input_b)
    |=> !safety_output_a) else $error("outputs on with chain missing");
  int_err_a: assert property (fault.internal_err |=> !safety_output_a ##1 led.red)
    else $error("internal error not shut down");
  imm_fault_a: assert property (fault.handle_bad || fault.actuator_bad
    |=> !safety_output_a) else $error("immediate fault not shut down");
  // ==========================================
  // diagnostics and bus
  diag_cond_a: assert property (diag_out |-> $past(guard) == 3'h7
    && $past(fault) == 7'h00) else $error("diag high without cause");
  warn_diag_a: assert property (fault != 7'h00 |=> !diag_out)
    else $error("diag high during fault");
  green_flash_a: assert property ((!chain_enable_input_a) [*8]
    |-> led.green != $past(led.green, GREEN_HALF_CYC)) else $error("green not flashing");
  ack_late_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : slc_checker

// [verification/slc_far_model.sv]
`timescale 1ns/1ps
module slc_far_model (
  input  wire logic clk,
  input  wire logic ptl,
  input  wire logic want_lock,
  output logic      magnet_ctrl_in
);
  assign magnet_ctrl_in = ptl ? want_lock : !want_lock;
endmodule : slc_far_model

// [verification/tb_slc_ctrl.sv]
`timescale 1ns/1ps
module tb_slc_ctrl;
  logic                clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic                ptl = 1'b0, want = 1'b1, ca = 1'b1, cb = 1'b1, ce = 1'b1;
  logic                mag, lk, sa, sb, dg, ack;
  logic [3:0]          adr = 4'h0;
  logic [31:0]         dat = 32'h0, rdo, q;
  slc_pkg::slc_guard_s guard = 3'h7;
  slc_pkg::slc_fault_s fault = 7'h00;
  slc_pkg::slc_led_s   led;
  int                  error_cnt = 0, compares = 0;
  slc_ctrl #(.ESC_CYC(50), .GREEN_HALF_CYC(4), .PULSE_CYC(3)) i_slc_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .magnet_ctrl_in(mag), .chain_enable_input_a(ca), .chain_enable_input_b(cb),
    .guard(guard), .fault(fault), .lock_engaged(lk), .safety_output_a(sa),
    .safety_output_b(sb), .diag_out(dg), .led(led));
  slc_far_model i_slc_far_model (.clk(clk), .ptl(ptl), .want_lock(want), .magnet_ctrl_in(mag));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  task give_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdo;
    {cyc, stb} <= 2'h0;
    error_cnt += (n >= 20);
    if (n >= 20)
      give_verdict();
  endtask : wb
  task reopen();
    guard <= 3'h3;
    tick(3);
    guard <= 3'h7;
    tick(4);
    chk(32'(sa), 1);
  endtask : reopen
  // ==========================================
  // scenarios
  task t_lock();
    tick(3);
    chk(32'({lk, sa, dg}), 7);
    want <= 1'b0;
    tick(4);
    chk(32'({lk, sa}), 0);
    want <= 1'b1;
    tick(4);
    chk(32'({lk, sa}), 3);
    ce <= 1'b0;
    want <= 1'b0;
    tick(4);
    chk(32'({lk, sa}), 3);
    ce <= 1'b1;
    want <= 1'b1;
    tick(4);
    $display("lock test done");
  endtask : t_lock
  task t_codes();
    for (int i = 0; i < 7; i++)
    begin
      fault <= 7'(1 << i);
      tick(3);
      chk(32'({sa, dg}), i < 4 ? 2 : 0);
      wb(1'b0, 4'h4, 32'h0);
      chk(32'(q[10:8]), i + 1);
      fault <= 7'h00;
      tick(3);
      chk(32'({sa, dg}), i < 4 ? 3 : 0);
      reopen();
    end
    $display("code test done");
  endtask : t_codes
  task t_esc();
    fault <= 7'h08;
    tick(45);
    chk(32'(sa), 1);
    tick(10);
    chk(32'(sa), 0);
    wb(1'b0, 4'h4, 32'h0);
    chk(32'({q[10:8], q[4]}), 9);
    fault <= 7'h00;
    tick(3);
    chk(32'(sa), 0);
    reopen();
    $display("escalation test done");
  endtask : t_esc
  task t_chain();
    for (int j = 1; j < 3; j++)
    begin
      {ca, cb} <= 2'(j);
      tick(12);
      chk(32'({sa, led.yellow, led.red}), 2);
      {ca, cb} <= 2'h3;
      tick(4);
      chk(32'(sa), 1);
    end
    $display("chain test done");
  endtask : t_chain
  task t_var();
    wb(1'b1, 4'h0, 32'h3);
    ptl <= 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk(q & 32'h3, 3);
    wb(1'b1, 4'h8, 32'hf);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 0);
    chk(32'({lk, sa}), 3);
    want <= 1'b0;
    tick(4);
    chk(32'({lk, sa}), 1);
    $display("variant test done");
  endtask : t_var
  initial
  begin
    tick(12);
    chk(32'(led), 4);
    rst <= 1'b0;
    t_lock();
    t_codes();
    t_esc();
    t_chain();
    t_var();
    give_verdict();
  end
endmodule : tb_slc_ctrl
bind slc_ctrl slc_checker #(.GREEN_HALF_CYC(GREEN_HALF_CYC)) i_slc_checker (
  .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .chain_enable_input_a(chain_enable_input_a),
  .chain_enable_input_b(chain_enable_input_b), .guard(guard), .fault(fault),
  .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
  .diag_out(diag_out), .led(led));
